// ### rtl/amis_regs.vh
// register offsets, field positions and reset values of the mute source selector
`ifndef AMIS_REGS_VH
`define AMIS_REGS_VH
`define AMIS_PORT1_CFG_ADDR  32'h4000001c
`define AMIS_PORT2_CFG_ADDR  32'h40000020
`define AMIS_SEL_MSB         2
`define AMIS_SEL_LSB         0
`define AMIS_SEL_RESET       3'h0
`define AMIS_SRC_ZERO        3'h0
`define AMIS_SRC_SECOND_SPI_CLOCK_PIN    3'h1
`define AMIS_SRC_SECOND_SPI_SLAVE_OUT_PIN   3'h2
`define AMIS_SRC_SECOND_SPI_SLAVE_IN_PIN   3'h3
`define AMIS_SRC_HFRX_CLK    3'h4
`define AMIS_SRC_FIRST_SPI_SLAVE_IN_PIN   3'h5
`define AMIS_SRC_SPI0_CS     3'h6
`define AMIS_SRC_FIRST_SPI_ENABLE_PIN    3'h7
`define AMIS_SYNC_STAGES     3
`endif

// ### rtl/amis_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module amis_pin_sync #(
  parameter WIDTH = 7
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  // s1 is read only by s2; a change counts when s2 and s3 agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= {WIDTH{1'b0}};
      s2 <= {WIDTH{1'b0}};
      s3 <= {WIDTH{1'b0}};
      q  <= {WIDTH{1'b0}};
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= (s2 & s3) | (q & (s2 | s3));
    end
  end
endmodule

// ### rtl/amis_mute_select.v
// mute input source selector for audio ports 1 and 2 with apb registers
//
// Overview of operation
// RULE1: port-1 config bits 2:0 are a read/write mute source select, reset 0.
// RULE2: port-2 config bits 2:0 are a read/write mute source select, reset 0.
// RULE3: code 000 drives the mute input with constant zero.
// RULE4: codes 001/010/011 pick second spi clock, slave-out, slave-in pins.
// RULE5: code 100 picks the port-2 high-frequency receive clock pin.
// RULE6: codes 101/110/111 pick first spi slave-in, chip-select, enable pins.
// RULE7: reserved bits 31:3 read undefined; software writes zeros there.
// RULE8: without the third port, the port-2 register is reserved and inert.
// RULE9: select changes take effect directly, sources pass a synchroniser.
`timescale 1ns/1ps
`include "amis_regs.vh"
module amis_mute_select #(
  parameter HAS_PORT2 = 1
) (
  input  wire        REF_CLK,
  input  wire        RESETN,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        SECOND_SPI_CLOCK_PIN,
  input  wire        SECOND_SPI_SLAVE_OUT_PIN,
  input  wire        SECOND_SPI_SLAVE_IN_PIN,
  input  wire        PORT2_HF_RECEIVE_CLOCK_PIN,
  input  wire        FIRST_SPI_SLAVE_IN_PIN,
  input  wire        FIRST_SPI_CHIP_SELECT_PIN,
  input  wire        FIRST_SPI_ENABLE_PIN,
  output reg         PORT1_MUTE_IN,
  output reg         PORT2_MUTE_IN
);

  // ************************************************
  // local constants
  // ************************************************
  // number of pin sources; code 0 is the constant zero and needs no pin
  localparam N_SRC = 7;
  // position of each source inside the synchronised pin vector
  localparam IDX_SECOND_SPI_CLOCK_PIN  = 0;
  localparam IDX_SECOND_SPI_SLAVE_OUT_PIN = 1;
  localparam IDX_SECOND_SPI_SLAVE_IN_PIN = 2;
  localparam IDX_HFRX_CLK  = 3;
  localparam IDX_FIRST_SPI_SLAVE_IN_PIN = 4;
  localparam IDX_SPI0_CS   = 5;
  localparam IDX_FIRST_SPI_ENABLE_PIN  = 6;

  // ************************************************
  // functions
  // ************************************************
  // full 32-bit compare; aliases of the two words are refused, not folded
  function addr_hit;
    input [31:0] addr;
    input [31:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // code 0 gives a constant zero so an idle port never mutes by accident
  function pick;
    input [2:0]       sel;
    input [N_SRC-1:0] src;
    begin
      case (sel)
        `AMIS_SRC_ZERO: begin
          pick = 1'b0; // RULE3
        end
        `AMIS_SRC_SECOND_SPI_CLOCK_PIN: begin
          pick = src[IDX_SECOND_SPI_CLOCK_PIN]; // RULE4
        end
        `AMIS_SRC_SECOND_SPI_SLAVE_OUT_PIN: begin
          pick = src[IDX_SECOND_SPI_SLAVE_OUT_PIN]; // RULE4
        end
        `AMIS_SRC_SECOND_SPI_SLAVE_IN_PIN: begin
          pick = src[IDX_SECOND_SPI_SLAVE_IN_PIN]; // RULE4
        end
        `AMIS_SRC_HFRX_CLK: begin
          pick = src[IDX_HFRX_CLK]; // RULE5
        end
        `AMIS_SRC_FIRST_SPI_SLAVE_IN_PIN: begin
          pick = src[IDX_FIRST_SPI_SLAVE_IN_PIN]; // RULE6
        end
        `AMIS_SRC_SPI0_CS: begin
          pick = src[IDX_SPI0_CS]; // RULE6
        end
        default: begin
          pick = src[IDX_FIRST_SPI_ENABLE_PIN]; // RULE6
        end
      endcase
    end
  endfunction

  // ************************************************
  // declarations
  // ************************************************
  reg  [2:0]       port1_mute_source_sel;
  reg  [2:0]       port2_mute_source_sel;
  reg  [2:0]       wr_sel1;
  reg  [2:0]       wr_sel2;
  reg  [2:0]       next_sel1;
  reg  [2:0]       next_sel2;
  reg  [31:0]      next_rdata;
  reg              next_err;
  wire             setup;
  wire             access;
  wire             commit;
  wire             hit1;
  wire             hit2;
  wire [N_SRC-1:0] pin_vec;
  wire [N_SRC-1:0] pins_q;

  assign setup   = PSEL & ~PENABLE;
  assign access  = PSEL & PENABLE & PREADY;
  assign commit  = access & PWRITE;
  assign hit1    = addr_hit(PADDR, `AMIS_PORT1_CFG_ADDR);
  assign hit2    = addr_hit(PADDR, `AMIS_PORT2_CFG_ADDR);
  assign pin_vec = {FIRST_SPI_ENABLE_PIN, FIRST_SPI_CHIP_SELECT_PIN, FIRST_SPI_SLAVE_IN_PIN,
                    PORT2_HF_RECEIVE_CLOCK_PIN, SECOND_SPI_SLAVE_IN_PIN, SECOND_SPI_SLAVE_OUT_PIN,
                    SECOND_SPI_CLOCK_PIN};

  // ************************************************
  // apb decode
  // ************************************************
  // zero-wait-state slave: decode in setup, answer with pready in access
  always @* begin
    next_sel1  = port1_mute_source_sel;
    next_sel2  = port2_mute_source_sel;
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (hit1) begin
      next_rdata = {29'h0, port1_mute_source_sel}; // RULE7
      if (PWRITE) begin
        next_sel1 = PWDATA[`AMIS_SEL_MSB:`AMIS_SEL_LSB]; // RULE1
      end
    end else if (hit2) begin
      // reduced variant: reads zero, writes dropped, no error
      if (HAS_PORT2 != 0) begin // RULE8
        next_rdata = {29'h0, port2_mute_source_sel}; // RULE7
        if (PWRITE) begin
          next_sel2 = PWDATA[`AMIS_SEL_MSB:`AMIS_SEL_LSB]; // RULE2
        end
      end
    end else begin
      next_err = 1'b1;
    end
  end

  // ************************************************
  // register storage
  // ************************************************
  // write data is captured in setup and committed at the access edge,
  // so a select changes exactly when pready is seen high
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_sel1 <= `AMIS_SEL_RESET;
      wr_sel2 <= `AMIS_SEL_RESET;
    end else if (setup) begin
      wr_sel1 <= next_sel1;
      wr_sel2 <= next_sel2;
    end else if (access) begin
      wr_sel1 <= wr_sel1;
      wr_sel2 <= wr_sel2;
    end else begin
      wr_sel1 <= port1_mute_source_sel;
      wr_sel2 <= port2_mute_source_sel;
    end
  end

  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      port1_mute_source_sel <= `AMIS_SEL_RESET; // RULE1
    end else if (commit) begin
      port1_mute_source_sel <= wr_sel1; // RULE1
    end
  end

  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      port2_mute_source_sel <= `AMIS_SEL_RESET; // RULE2
    end else if (commit) begin
      port2_mute_source_sel <= wr_sel2; // RULE2
    end
  end

  // ************************************************
  // apb response
  // ************************************************
  // every response output is a flop; pready is a single pulse
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup;
    end
  end

  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= setup & next_err;
    end
  end

  // read data only in the access cycle; reserved bits read zero
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
    end else begin
      PRDATA <= (setup & ~PWRITE) ? next_rdata : 32'h00000000;
    end
  end

  // ************************************************
  // source synchronisation and selection
  // ************************************************
  // the hf clock is sampled like any pin; only slow mute levels survive intact
  amis_pin_sync #(
    .WIDTH (N_SRC)
  ) u_sync (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .d     (pin_vec),
    .q     (pins_q)
  ); // RULE9

  // a select change needs no update command; the output follows next edge
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PORT1_MUTE_IN <= 1'b0;
      PORT2_MUTE_IN <= 1'b0;
    end else begin
      PORT1_MUTE_IN <= pick(port1_mute_source_sel, pins_q); // RULE9
      PORT2_MUTE_IN <= (HAS_PORT2 != 0) ? pick(port2_mute_source_sel, pins_q) : 1'b0; // RULE8
    end
  end
endmodule

// ### bench/amis_monitor.sv
// assertion checker for the mute source selector
`timescale 1ns/1ps
`include "amis_regs.vh"
module amis_monitor #(parameter HAS_PORT2 = 1) (
  input wire        REF_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PORT1_MUTE_IN, PORT2_MUTE_IN,
  input wire [31:0] PADDR, PWDATA, PRDATA);
  reg  [2:0] s1, s2;
  wire       h1 = PADDR == `AMIS_PORT1_CFG_ADDR, h2 = PADDR == `AMIS_PORT2_CFG_ADDR;
  wire       wr = PSEL && PENABLE && PREADY && PWRITE;
  // shadow selects; port-2 copy stays 0 on the reduced variant since writes there are inert
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
    end else begin
      if (wr && h1) s1 <= PWDATA[2:0];
      if (wr && h2 && HAS_PORT2 != 0) s2 <= PWDATA[2:0];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence rd_s; PSEL && PENABLE && PREADY && !PWRITE; endsequence
  a_ready_after_setup: assert property (setup_s |=> PREADY) else $error("no ready after setup");
  a_ready_one_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_err_unmapped: assert property (PREADY |-> PSLVERR == (!h1 && !h2)) else $error("error flag");
  a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("stray error");
  a_read_sel_one: assert property (rd_s ##0 h1 |-> PRDATA[2:0] == s1) else $error("port1 readback");
  a_read_sel_two: assert property (rd_s ##0 h2 |-> PRDATA[2:0] == s2) else $error("port2 readback");
  a_zero_code_one: assert property (s1 == 3'h0 |=> !PORT1_MUTE_IN) else $error("port1 not zero");
  a_zero_code_two: assert property (s2 == 3'h0 |=> !PORT2_MUTE_IN) else $error("port2 not zero");
endmodule
bind amis_mute_select amis_monitor #(.HAS_PORT2(HAS_PORT2)) i_mon (.*);

// ### bench/audio_mute_input_select_tb.sv
// self-checking bench for the mute source selector
`timescale 1ns/1ps
`include "amis_regs.vh"
module audio_mute_input_select_tb;
  logic        REF_CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, PORT1_MUTE_IN, PORT2_MUTE_IN;
  logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, rd, PRDATA_L, rdl;
  logic        PREADY_L, PSLVERR_L, MUTE1_L, MUTE2_L, err;
  logic [6:0]  pins = 0;
  int          n_errors = 0, comparisons = 0;
  amis_mute_select i_dut (.*, .SECOND_SPI_CLOCK_PIN(pins[0]), .SECOND_SPI_SLAVE_OUT_PIN(pins[1]),
    .SECOND_SPI_SLAVE_IN_PIN(pins[2]), .PORT2_HF_RECEIVE_CLOCK_PIN(pins[3]), .FIRST_SPI_SLAVE_IN_PIN(pins[4]),
    .FIRST_SPI_CHIP_SELECT_PIN(pins[5]), .FIRST_SPI_ENABLE_PIN(pins[6]));
  // reduced variant shares the bus; port-2 register must stay inert there
  amis_mute_select #(.HAS_PORT2(0)) i_dut_lite (.REF_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA(PRDATA_L), .PREADY(PREADY_L), .PSLVERR(PSLVERR_L), .SECOND_SPI_CLOCK_PIN(pins[0]),
    .SECOND_SPI_SLAVE_OUT_PIN(pins[1]), .SECOND_SPI_SLAVE_IN_PIN(pins[2]), .PORT2_HF_RECEIVE_CLOCK_PIN(pins[3]),
    .FIRST_SPI_SLAVE_IN_PIN(pins[4]), .FIRST_SPI_CHIP_SELECT_PIN(pins[5]), .FIRST_SPI_ENABLE_PIN(pins[6]),
    .PORT1_MUTE_IN(MUTE1_L), .PORT2_MUTE_IN(MUTE2_L));
  initial forever #5 REF_CLK = ~REF_CLK;
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin n_errors++; $display("wrong value %s expected %h seen %h", nm, e, s); end
  endtask
  // leading edge keeps one idle cycle between transfers, so no signal is driven twice in a step
  task automatic xfer(input logic w, input logic [31:0] a, d);
    int k = 0;
    @(posedge REF_CLK) {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge REF_CLK) PENABLE <= 1;
    do @(posedge REF_CLK) k++; while (PREADY !== 1'b1 && k < 20);
    rd = PRDATA;
    rdl = PRDATA_L;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
    if (PREADY !== 1'b1) begin n_errors++; tally_and_finish(); end
  endtask
  initial begin
    repeat (6) @(posedge REF_CLK);
    RESETN <= 1;
    for (int r = 0; r < 2; r++) begin
      xfer(0, `AMIS_PORT1_CFG_ADDR, 0); chk("cfg1", 0, rd[2:0]);
      xfer(0, `AMIS_PORT2_CFG_ADDR, 0); chk("cfg2", 0, rd[2:0]);
      $display("test reset values done");
      for (int c = 0; c < 8; c++) begin
        xfer(1, `AMIS_PORT1_CFG_ADDR, c); xfer(1, `AMIS_PORT2_CFG_ADDR, 7 - c);
        xfer(0, `AMIS_PORT1_CFG_ADDR, 0); chk("cfg1", c, rd[2:0]);
        xfer(0, `AMIS_PORT2_CFG_ADDR, 0); chk("cfg2", 7 - c, rd[2:0]);
        chk("lite cfg2", 0, rdl[2:0]);
        chk("no error", 0, err);
        for (int p = 0; p < 2; p++) begin
          @(posedge REF_CLK) pins <= p ? 7'h2a : 7'h55;
          repeat (8) @(posedge REF_CLK);
          chk("mute1", c ? pins[c - 1] : 0, PORT1_MUTE_IN);
          chk("mute2", c < 7 ? pins[6 - c] : 0, PORT2_MUTE_IN);
          chk("lite mute1", c ? pins[c - 1] : 0, MUTE1_L);
          chk("lite mute2", 0, MUTE2_L);
        end
      end
      $display("test source routing done");
      xfer(0, 32'h40000024, 0); chk("error flag", 1, err);
      $display("test unmapped access done");
      @(posedge REF_CLK) RESETN <= 0;
      repeat (2) @(posedge REF_CLK);
      RESETN <= 1;
    end
    tally_and_finish();
  end
endmodule
